// ===== logic/btd_core.v
// Bit test, set and clear execution unit with its data memory, flags and ports, behind AHB-Lite.
// Assumes one 100 MHz clock, a single AHB-Lite master doing word transfers, and external pins.
//
// Summary of operation
// - Prefix 0x39 with second byte 10bbyyyy loads the branch flag with the inverse of bit b of page-zero word y.
// - Prefix 0x3B with second byte 10bbpppp loads the branch flag with the inverse of bit b of port p.
// - A port bit tested by the 0x3B forms comes from the output register for output-only ports and from the pin otherwise.
// - Opcode 0x37 loads the branch flag with the inverse pin bit L[1:0] of port L[3:2]+4.
// - Opcode 0x04 copies the carry flag into the branch flag and then sets the carry flag.
// - Opcode 0x0E copies the zero flag into the branch flag and leaves carry and zero alone.
// - The one-byte general-flag true test copies the general flag into the branch flag.
// - Prefix 0x39 with second byte 11bbyyyy loads the branch flag with bit b of page-zero word y.
// - Prefix 0x3B with second byte 11bbpppp loads the branch flag with bit b of port p.
// - Opcode 0x03 sets the general flag and the branch flag.
// - Opcode 010100bb sets bit b of the memory word addressed by H and L, other bits kept.
// - Prefix 0x39 with second byte 00bbyyyy sets bit b of page-zero word y.
// - Opcode 0x02 clears the general flag and sets the branch flag.
`timescale 1ns/10ps
`include "btd_map.vh"

module btd_core #(
    parameter NPORT = 16,
    parameter MEM_AW = 8
) (
    CLK,
    RST_B,
    HSEL,
    HADDR,
    HTRANS,
    HWRITE,
    HSIZE,
    HWDATA,
    HREADY,
    HRDATA,
    HREADYOUT,
    HRESP,
    PIN_IN,
    PORT_OUT,
    PORT_OE_B,
    BRANCH_FLAG
);
    input wire CLK;
    input wire RST_B;
    input wire HSEL;
    input wire [31:0] HADDR;
    input wire [1:0] HTRANS;
    input wire HWRITE;
    input wire [2:0] HSIZE;
    input wire [31:0] HWDATA;
    input wire HREADY;
    output reg [31:0] HRDATA;
    output reg HREADYOUT;
    output reg HRESP;
    input wire [4*NPORT-1:0] PIN_IN;
    output reg [4*NPORT-1:0] PORT_OUT;
    output reg [4*NPORT-1:0] PORT_OE_B;
    output reg BRANCH_FLAG;

    reg [3:0] mem [0:(1<<MEM_AW)-1];
    reg [4*NPORT-1:0] pin_s1_q, pin_s2_q;
    reg [2*NPORT-1:0] ptype_q;
    wire [4*NPORT-1:0] oe_b_d;
    reg [3:0] flags_q, h_q, l_q;
    reg [MEM_AW-1:0] maddr_q;
    reg [15:0] instr_q;
    reg bad_q, wr_pend_q, rd_pend_q;
    reg [7:0] addr_q;
    reg [31:0] rd_d;
    wire accept, exec, port_bit;
    wire [7:0] op1, op2;
    wire [1:0] bsel, fld_type;
    wire [3:0] fld, mem_y, mem_hl;
    wire [5:0] l_idx;

    // Decode controls of the execution cycle.
    reg sf_we, sf_d, cf_we, gf_we, gf_d, mw_we, pw_we, bad_d;
    reg [MEM_AW-1:0] mw_a;
    reg [3:0] mw_d;
    reg [5:0] pw_idx;

    // An address phase is taken only when the bus is ready and the transfer is real.
    assign accept = HSEL & HTRANS[1] & HREADY;
    assign exec = wr_pend_q & (addr_q == `BTD_A_INSTR);
    assign op1 = HWDATA[7:0];
    assign op2 = HWDATA[15:8];
    assign bsel = op2[5:4];
    assign fld = op2[3:0];
    assign l_idx = {`BTD_L_PORT_BASE, l_q}; // Port L[3:2]+4, bit L[1:0].
    assign mem_y = mem[{{(MEM_AW-4){1'b0}}, fld}];
    assign mem_hl = mem[{h_q, l_q}];
    assign fld_type = ptype_q[{fld, 1'b0} +: 2];
    // Output-only ports show their register, the rest show the pin.
    assign port_bit = (fld_type == `BTD_PT_OUT) ? PORT_OUT[{fld, bsel}] : pin_s2_q[{fld, bsel}];

    // Instruction decode; the bytes are taken from the data phase of an INSTR write.
    always @* begin
        sf_we = 1'b0;
        sf_d = 1'b0;
        cf_we = 1'b0;
        gf_we = 1'b0;
        gf_d = 1'b0;
        mw_we = 1'b0;
        mw_a = {h_q, l_q};
        mw_d = mem_hl;
        pw_we = 1'b0;
        pw_idx = l_idx;
        bad_d = 1'b0;
        if (op1[7:3] == `BTD_OP_HL_HI) begin
            // Bit 2 of the opcode picks clear over set; every other bit is kept.
            mw_we = 1'b1;
            mw_d[op1[1:0]] = ~op1[2];
            sf_we = 1'b1;
            sf_d = 1'b1;
        end else begin
            case (op1)
                `BTD_OP_PFX_MEM: begin
                    case (op2[7:6])
                        `BTD_M2_TEST: begin
                            sf_we = 1'b1;
                            sf_d = ~mem_y[bsel];
                        end
                        `BTD_M2_TEST_BIT_TRUE_OP: begin
                            sf_we = 1'b1;
                            sf_d = mem_y[bsel];
                        end
                        `BTD_M2_SET: begin
                            mw_we = 1'b1;
                            mw_a = {{(MEM_AW-4){1'b0}}, fld};
                            mw_d = mem_y;
                            mw_d[bsel] = 1'b1;
                            sf_we = 1'b1;
                            sf_d = 1'b1;
                        end
                        default: bad_d = 1'b1;
                    endcase
                end
                `BTD_OP_PFX_PORT: begin
                    case (op2[7:6])
                        `BTD_M2_TEST: begin
                            sf_we = 1'b1;
                            sf_d = ~port_bit;
                        end
                        `BTD_M2_TEST_BIT_TRUE_OP: begin
                            sf_we = 1'b1;
                            sf_d = port_bit;
                        end
                        `BTD_M2_SET: begin
                            pw_we = 1'b1;
                            pw_idx = {fld, bsel};
                            sf_we = 1'b1;
                            sf_d = 1'b1;
                        end
                        default: bad_d = 1'b1;
                    endcase
                end
                `BTD_OP_TEST_L: begin
                    sf_we = 1'b1;
                    sf_d = ~pin_s2_q[l_idx];
                end
                `BTD_OP_SET_L: begin
                    pw_we = 1'b1;
                    sf_we = 1'b1;
                    sf_d = 1'b1;
                end
                `BTD_OP_TCARRY: begin
                    sf_we = 1'b1;
                    sf_d = flags_q[`BTD_F_CARRY];
                    cf_we = 1'b1;
                end
                `BTD_OP_TZERO: begin
                    sf_we = 1'b1;
                    sf_d = flags_q[`BTD_F_ZERO];
                end
                `BTD_OP_TGEN: begin
                    sf_we = 1'b1;
                    sf_d = flags_q[`BTD_F_GENERAL];
                end
                `BTD_OP_SETGEN: begin
                    gf_we = 1'b1;
                    gf_d = 1'b1;
                    sf_we = 1'b1;
                    sf_d = 1'b1;
                end
                `BTD_OP_CLRGEN: begin
                    gf_we = 1'b1;
                    gf_d = 1'b0;
                    sf_we = 1'b1;
                    sf_d = 1'b1;
                end
                default: bad_d = 1'b1;
            endcase
        end
    end

    // Pin inputs pass two flip-flops; only the second stage feeds any logic.
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            pin_s1_q <= {(4*NPORT){1'b0}};
            pin_s2_q <= {(4*NPORT){1'b0}};
        end else begin
            pin_s1_q <= PIN_IN;
            pin_s2_q <= pin_s1_q;
        end
    end

    // Input ports are released, output and two-way ports drive their pins.
    genvar gi;
    generate
        for (gi = 0; gi < NPORT; gi = gi + 1) begin : g_oe
            // One continuous driver per slice keeps each pin enable to a single source.
            assign oe_b_d[4*gi +: 4] = {4{ptype_q[2*gi +: 2] == `BTD_PT_IN}};
        end
    endgenerate

    // Bus handshake: writes finish with no wait, reads insert one wait so that
    // the data reflect every earlier write and instruction.
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            addr_q <= 8'h00;
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            HRDATA <= 32'h00000000;
        end else begin
            wr_pend_q <= accept & HWRITE;
            if (accept) begin
                addr_q <= HADDR[7:0];
            end
            if (accept & ~HWRITE) begin
                rd_pend_q <= 1'b1;
                HREADYOUT <= 1'b0;
            end else if (rd_pend_q) begin
                rd_pend_q <= 1'b0;
                HREADYOUT <= 1'b1;
                HRDATA <= rd_d;
            end
        end
    end

    // Read multiplexer; unmapped offsets read as zero.
    always @* begin
        rd_d = 32'h00000000;
        if (addr_q == `BTD_A_INSTR) begin
            rd_d[15:0] = instr_q;
        end else if (addr_q == `BTD_A_FLAGS) begin
            rd_d[3:0] = flags_q;
        end else if (addr_q == `BTD_A_PTR) begin
            rd_d[7:0] = {h_q, l_q};
        end else if (addr_q == `BTD_A_PTYPE) begin
            rd_d[2*NPORT-1:0] = ptype_q;
        end else if (addr_q == `BTD_A_STATUS) begin
            rd_d[0] = bad_q;
        end else if (addr_q == `BTD_A_MADDR) begin
            rd_d[MEM_AW-1:0] = maddr_q;
        end else if (addr_q == `BTD_A_MDATA) begin
            rd_d[3:0] = mem[maddr_q];
        end else if (addr_q == `BTD_A_PORT_LO) begin
            rd_d = PORT_OUT[31:0];
        end else if (addr_q == `BTD_A_PORT_HI) begin
            rd_d = PORT_OUT[63:32];
        end else if (addr_q == `BTD_A_PIN_LO) begin
            rd_d = pin_s2_q[31:0];
        end else if (addr_q == `BTD_A_PIN_HI) begin
            rd_d = pin_s2_q[63:32];
        end
    end

    // Software registers and the flag and port effects of each instruction.
    // Instructions arrive as INSTR writes, so a bus write and an instruction never act in the same cycle.
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            flags_q <= `BTD_RST_FLAGS;
            h_q <= 4'h0;
            l_q <= 4'h0;
            ptype_q <= `BTD_RST_PTYPE;
            maddr_q <= {MEM_AW{1'b0}};
            instr_q <= 16'h0000;
            bad_q <= 1'b0;
            PORT_OUT <= {(4*NPORT){1'b0}};
            PORT_OE_B <= {(4*NPORT){1'b1}};
            BRANCH_FLAG <= 1'b0;
        end else begin
            PORT_OE_B <= oe_b_d;
            BRANCH_FLAG <= flags_q[`BTD_F_BRANCH];
            if (exec) begin
                instr_q <= HWDATA[15:0];
                bad_q <= bad_d;
                if (sf_we) begin
                    flags_q[`BTD_F_BRANCH] <= sf_d;
                end
                if (cf_we) begin
                    flags_q[`BTD_F_CARRY] <= 1'b1;
                end
                if (gf_we) begin
                    flags_q[`BTD_F_GENERAL] <= gf_d;
                end
                if (pw_we) begin
                    PORT_OUT[pw_idx] <= 1'b1;
                end
            end else if (wr_pend_q) begin
                if (addr_q == `BTD_A_FLAGS) begin
                    flags_q <= HWDATA[3:0];
                end else if (addr_q == `BTD_A_PTR) begin
                    h_q <= HWDATA[7:4];
                    l_q <= HWDATA[3:0];
                end else if (addr_q == `BTD_A_PTYPE) begin
                    ptype_q <= HWDATA[2*NPORT-1:0];
                end else if (addr_q == `BTD_A_MADDR) begin
                    maddr_q <= HWDATA[MEM_AW-1:0];
                end else if (addr_q == `BTD_A_PORT_LO) begin
                    PORT_OUT[31:0] <= HWDATA;
                end else if (addr_q == `BTD_A_PORT_HI) begin
                    PORT_OUT[63:32] <= HWDATA;
                end
            end
        end
    end

    // Data memory has no reset; software initialises it through the window.
    always @(posedge CLK) begin
        if (exec & mw_we) begin
            mem[mw_a] <= mw_d;
        end else if (wr_pend_q & (addr_q == `BTD_A_MDATA)) begin
            mem[maddr_q] <= HWDATA[3:0];
        end
    end

endmodule // btd_core

// ===== logic/btd_map.vh
// Register offsets, field positions, reset values and opcodes of the bit test/set/clear block.
// Assumes a 32-bit AHB-Lite bus with word-aligned single transfers; offsets are byte addresses.
`ifndef BTD_MAP_VH
`define BTD_MAP_VH

// Register byte offsets (low address byte only is decoded).
`define BTD_A_INSTR 8'h00
`define BTD_A_FLAGS 8'h04
`define BTD_A_PTR 8'h08
`define BTD_A_PTYPE 8'h0C
`define BTD_A_STATUS 8'h10
`define BTD_A_MADDR 8'h14
`define BTD_A_MDATA 8'h18
`define BTD_A_PORT_LO 8'h20
`define BTD_A_PORT_HI 8'h24
`define BTD_A_PIN_LO 8'h28
`define BTD_A_PIN_HI 8'h2C

// Flag bit positions in the FLAGS register.
`define BTD_F_CARRY 0
`define BTD_F_ZERO 1
`define BTD_F_GENERAL 2
`define BTD_F_BRANCH 3

// Port type codes, two bits per port in PTYPE.
`define BTD_PT_OUT 2'h0
`define BTD_PT_IN 2'h1

// Reset values.
`define BTD_RST_PTYPE 32'h55555555
`define BTD_RST_FLAGS 4'h0

// First-byte opcodes.
`define BTD_OP_PFX_MEM 8'h39
`define BTD_OP_PFX_PORT 8'h3B
`define BTD_OP_TEST_L 8'h37
`define BTD_OP_SET_L 8'h34
`define BTD_OP_TCARRY 8'h04
`define BTD_OP_TZERO 8'h0E
`define BTD_OP_TGEN 8'h01
`define BTD_OP_SETGEN 8'h03
`define BTD_OP_CLRGEN 8'h02
`define BTD_OP_HL_HI 5'h0A

// Second-byte mode field values.
`define BTD_M2_TEST 2'h2
`define BTD_M2_TEST_BIT_TRUE_OP 2'h3
`define BTD_M2_SET 2'h0

// Upper two bits of the port number used by the indirect L forms.
`define BTD_L_PORT_BASE 2'h1

`endif

// ===== tb/btd_core_assertions.sv
// Port-level checks of the bit test/set/clear core.
// Assumes HREADY is fed from HREADYOUT and a single AHB-Lite master.
`timescale 1ns/10ps
module btd_core_assertions #(
    parameter NPORT = 16
) (
    input wire CLK,
    input wire RST_B,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    input wire [31:0] HRDATA,
    input wire HREADYOUT,
    input wire HRESP,
    input wire [4*NPORT-1:0] PORT_OUT,
    input wire BRANCH_FLAG
);
    reg wr_instr_q;
    reg rd_q;
    reg [5:0] pidx_q;
    wire taken;

    // An address phase is accepted only with select, a real transfer and ready.
    assign taken = HSEL && HTRANS[1] && HREADY;

    // Remember which data phase follows, since HWDATA only carries the instruction then.
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            wr_instr_q <= 1'b0;
            rd_q <= 1'b0;
            pidx_q <= 6'h00;
        end else begin
            wr_instr_q <= taken && HWRITE && (HADDR[7:0] == 8'h00);
            rd_q <= taken && !HWRITE;
            pidx_q <= {HWDATA[11:8], HWDATA[13:12]};
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    sequence s_rd_taken;
        taken && !HWRITE;
    endsequence
    sequence s_one_wait;
        !HREADYOUT ##1 HREADYOUT;
    endsequence

    a_setgen_branch: assert property (wr_instr_q && HWDATA[7:0] == 8'h03 |-> ##2 BRANCH_FLAG)
        else $error("Branch flag not set after general flag set.");
    a_clrgen_branch: assert property (wr_instr_q && HWDATA[7:0] == 8'h02 |-> ##2 BRANCH_FLAG)
        else $error("Branch flag not set after general flag clear.");
    a_memclr_branch: assert property (wr_instr_q && HWDATA[7:2] == 6'h15 |-> ##2 BRANCH_FLAG)
        else $error("Branch flag not set after memory bit clear.");
    a_port_set: assert property (wr_instr_q && HWDATA[7:0] == 8'h3B && HWDATA[15:14] == 2'h0
        |=> PORT_OUT[pidx_q])
        else $error("Port bit not set by port set form.");
    a_read_wait: assert property (s_rd_taken |=> s_one_wait)
        else $error("Read did not take exactly one wait state.");
    a_write_nowait: assert property (taken && HWRITE |=> HREADYOUT)
        else $error("Write data phase was stalled.");
    a_resp_okay: assert property (!HRESP)
        else $error("Response was not OKAY.");
    a_rdata_hold: assert property ($changed(HRDATA) |-> $past(rd_q))
        else $error("Read data changed outside a read.");
endmodule // btd_core_assertions

// ===== tb/test_bit_test_set_clear_decoder.sv
// Self-checking bench of the bit test/set/clear core against a reference model.
// Assumes the core alone on the AHB-Lite bus, with HREADY fed from HREADYOUT.
`timescale 1ns/10ps
`include "btd_map.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); end end
module test_bit_test_set_clear_decoder;
    logic CLK, RST_B, HSEL, HWRITE;
    logic [31:0] HADDR, HWDATA, rd, r;
    logic [1:0] HTRANS;
    logic [63:0] PIN_IN, po, pi;
    wire [31:0] HRDATA;
    wire HREADYOUT, HRESP, BRANCH_FLAG;
    wire [63:0] PORT_OUT, PORT_OE_B;
    logic [3:0] f, k, y, p, mem [0:31];
    logic [7:0] ptr, ot [0:8];
    logic [15:0] w;
    logic [5:0] pb;
    logic [1:0] b, mt [0:2];
    int miscompares, tests_run, ma;

    btd_core #(.NPORT(16), .MEM_AW(8)) dut (.CLK(CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PIN_IN(PIN_IN), .PORT_OUT(PORT_OUT),
        .PORT_OE_B(PORT_OE_B), .BRANCH_FLAG(BRANCH_FLAG));

    // Free-running 100 MHz clock.
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // One single-word transfer; each phase is held until HREADY is seen high at an edge.
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HADDR <= {24'h0, a};
        HTRANS <= 2'h2;
        HWRITE <= wr;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(rd & m, e)
    endtask

    task finish_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // A hang costs a mismatch; the run needs well under a fifth of this span.
    initial begin
        #200000;
        miscompares++;
        finish_test();
    end

    // Ports 0-7 are output-only, so their 0x3B tests read the output register; 0x37 tests and ports 8-15 read pins.
    initial begin
        RST_B = 1'b0;
        HSEL = 1'b0;
        HADDR = 32'h0;
        HTRANS = 2'h0;
        HWRITE = 1'b0;
        HWDATA = 32'h0;
        PIN_IN = 64'h0;
        mt = '{2'h2, 2'h3, 2'h0};
        ot = '{`BTD_OP_TEST_L, `BTD_OP_SET_L, `BTD_OP_TCARRY, `BTD_OP_TZERO, `BTD_OP_TGEN,
            `BTD_OP_SETGEN, `BTD_OP_CLRGEN, 8'h50, 8'h54};
        repeat (2) @(posedge CLK);
        RST_B <= 1'b1;
        @(posedge CLK);
        rdc(`BTD_A_PTYPE, 32'hFFFFFFFF, `BTD_RST_PTYPE);
        rdc(`BTD_A_FLAGS, 32'hF, 32'h0);
        rdc(8'h3C, 32'hFFFFFFFF, 32'h0);
        xfer(1'b1, `BTD_A_STATUS, 32'h1);
        rdc(`BTD_A_STATUS, 32'h1, 32'h0);
        xfer(1'b1, `BTD_A_PTYPE, 32'hFEA50000); // Ports 8-9 input, 10-15 two-way, so both pin paths run.
        r = xs(32'h03D9054D);
        po = {32'h0, r};
        xfer(1'b1, `BTD_A_PORT_LO, r);
        `CHK(PORT_OE_B, {32'h000000FF, 32'h0})
        for (int i = 0; i < 32; i++) begin
            r = xs(r);
            mem[i] = r[3:0];
            xfer(1'b1, `BTD_A_MADDR, i);
            xfer(1'b1, `BTD_A_MDATA, {28'h0, r[3:0]});
        end
        for (int n = 0; n < 80; n++) begin
            r = xs(r);
            pi[31:0] = r;
            r = xs(r);
            pi[63:32] = r;
            PIN_IN <= pi;
            r = xs(r);
            f = r[3:0];
            ptr = {3'h0, r[8], r[7:4]};
            k = r[12:9];
            b = r[14:13];
            y = r[19:16];
            p = r[23:20];
            pb = {p, b};
            ma = (k > 12) ? ptr[4:0] : y;
            xfer(1'b1, `BTD_A_FLAGS, {28'h0, f});
            xfer(1'b1, `BTD_A_PTR, {24'h0, ptr});
            if (k < 6 || k == 15) begin
                w = {(k == 15) ? 2'h1 : mt[k % 3], b, (k < 3 || k == 15) ? {y, 8'h39} : {p, 8'h3B}};
            end else begin
                w = {8'h0, ot[k - 6] | ((k > 12) ? {6'h0, b} : 8'h0)};
            end
            if (k inside {2, 5, 7, 11, 12, 13, 14}) f[3] = 1'b1;
            case (k)
                0: f[3] = ~mem[y][b];
                1: f[3] = mem[y][b];
                2: mem[y][b] = 1'b1;
                3: f[3] = ~(p[3] ? pi[pb] : po[pb]);
                4: f[3] = p[3] ? pi[pb] : po[pb];
                5: po[pb] = 1'b1;
                6: f[3] = ~pi[{2'h1, ptr[3:0]}];
                7: po[{2'h1, ptr[3:0]}] = 1'b1;
                8: f = {f[0], f[2:1], 1'b1};
                9: f[3] = f[1];
                10: f[3] = f[2];
                11: f[2] = 1'b1;
                12: f[2] = 1'b0;
                13: mem[ma][b] = 1'b1;
                14: mem[ma][b] = 1'b0;
                default: ;
            endcase
            xfer(1'b1, `BTD_A_INSTR, {16'h0, w});
            rdc(`BTD_A_FLAGS, 32'hF, {28'h0, f});
            `CHK(BRANCH_FLAG, f[3])
            rdc(`BTD_A_STATUS, 32'h1, {31'h0, k == 15});
            `CHK(PORT_OUT, po)
            xfer(1'b1, `BTD_A_MADDR, ma);
            rdc(`BTD_A_MDATA, 32'hF, {28'h0, mem[ma]});
        end
        rdc(`BTD_A_PIN_HI, 32'hFFFFFFFF, pi[63:32]);
        finish_test();
    end
endmodule // test_bit_test_set_clear_decoder

bind btd_core btd_core_assertions #(.NPORT(NPORT)) u_chk (.CLK(CLK), .RST_B(RST_B), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PORT_OUT(PORT_OUT), .BRANCH_FLAG(BRANCH_FLAG));
